// File: src/sfdwe_pkg.sv
/*
 * constants and carrier types for the selective fd wake emulation mode controller.
 * assumes a frame decoder upstream that delivers accepted classical frames as one-cycle pulses,
 * and a controller core downstream that honours the mode, clear, cancel and transmit outputs.
 */
package sfdwe_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam logic [10:0] WAKE_ID = 11'h000;
    localparam int unsigned FLAG_FD_POS = 0;
    localparam int unsigned FLAG_CL_POS = 1;
    localparam int unsigned INTEGRATION_BITS = 13;
    localparam int unsigned MODE_CHANGE_CLKS = 50;
    localparam int unsigned BIT_CLKS = 50;
    localparam logic [10:0] ECHO_ID_XOR = 11'h001;
    localparam logic [1:0] MODE_RX_ONLY = 2'h0;
    localparam logic [1:0] MODE_RESET = 2'h1;
    localparam logic [1:0] MODE_HALT = 2'h2;
    localparam logic [1:0] MODE_OPERATE = 2'h3;
    localparam logic [3:0] REG_CTRL_OFS = 4'h0;
    localparam logic [3:0] REG_STATUS_OFS = 4'h4;
    localparam logic [3:0] REG_COUNT_OFS = 4'h8;

    typedef struct packed {
        logic [10:0] id;
        logic [3:0] dlc;
        logic [63:0] data;
    } sfdwe_frame_t;

    typedef enum {
        SFDWE_LISTEN,
        SFDWE_RESET,
        SFDWE_CHANGE,
        SFDWE_INTEGRATE,
        SFDWE_OPERATE,
        SFDWE_CANCEL,
        SFDWE_HALT
    } sfdwe_state_t;
endpackage : sfdwe_pkg

// File: src/sfdwe_idle_counter.sv
/*
 * counts consecutive recessive bit times on the synchronised receive level.
 * assumes bit_en is a one-cycle pulse at each bit sample point.
 */
`timescale 1ns/1ps
module sfdwe_idle_counter #(
    parameter int unsigned NEED = 13
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // control
    input wire logic clear,
    input wire logic bit_en,
    input wire logic rx_level,
    // result
    output logic done
);
    logic [7:0] count;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            count <= 8'h00;
        else if (clear)
            count <= 8'h00;
        else if (bit_en && !rx_level)
            count <= 8'h00;
        else if (bit_en && !done)
            count <= count + 8'h01;
    end

    assign done = (count >= 8'(NEED));
endmodule : sfdwe_idle_counter

// File: src/sfdwe_top.sv
/*
 * mode controller letting a classical-only node share an fd bus by emulated partial networking.
 * assumes frames arrive already decoded and accepted as one-cycle pulses on ref_clk,
 * that can_rx is the raw bus receive pin, and that the core obeys ctrl_mode, the other core control and tx_* outputs.
 */
`timescale 1ns/1ps
module sfdwe_top #(
    parameter int unsigned MODE_CLKS = sfdwe_pkg::MODE_CHANGE_CLKS,
    parameter int unsigned BIT_CYCLES = sfdwe_pkg::BIT_CLKS,
    parameter bit FD_NODE = 1'b0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // bus receive pin
    input wire logic can_rx,
    // received classical frames
    input wire logic rx_valid,
    input wire sfdwe_pkg::sfdwe_frame_t rx_frame,
    // transmit request to the core
    output logic tx_valid,
    output sfdwe_pkg::sfdwe_frame_t tx_frame,
    input wire logic tx_ready,
    // core control
    output logic [1:0] ctrl_mode,
    output logic clear_errors,
    output logic cancel_pending,
    output logic tx_drive_allow,
    output logic listen_enable,
    input wire logic pending_empty,
    // software view
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata
);
    // ****************
    // register map
    // ****************
    localparam logic [3:0] REG_CTRL = sfdwe_pkg::REG_CTRL_OFS;
    localparam logic [3:0] REG_STATUS = sfdwe_pkg::REG_STATUS_OFS;
    localparam logic [3:0] REG_COUNT = sfdwe_pkg::REG_COUNT_OFS;

    sfdwe_pkg::sfdwe_state_t state, next_state;
    logic [2:0] rx_sync;
    logic rx_level;
    logic [7:0] bit_div;
    logic bit_en;
    logic [7:0] mode_cnt;
    logic echo_enable;
    logic [15:0] wake_count;
    logic echo_pending;
    sfdwe_pkg::sfdwe_frame_t echo_frame;
    logic integ_done;

    // ****************
    // pin sampling and bit rate enable
    // ****************
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            rx_sync <= 3'b111;
        else
            rx_sync <= {rx_sync[1:0], can_rx};
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            rx_level <= 1'b1;
        else if (rx_sync[1] == rx_sync[2])
            rx_level <= rx_sync[2];
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            bit_div <= 8'h00;
        else if (bit_en)
            bit_div <= 8'h00;
        else
            bit_div <= bit_div + 8'h01;
    end

    assign bit_en = (bit_div == 8'(BIT_CYCLES - 1));

    // ****************
    // wake-up frame decode
    // ****************
    function automatic logic is_wake(input sfdwe_pkg::sfdwe_frame_t f);
        return (f.id == sfdwe_pkg::WAKE_ID) && (f.dlc != 4'h0);
    endfunction : is_wake

    wire wake_seen = rx_valid && is_wake(rx_frame);
    // fd node acts on the fd flag, classical node on the classical flag
    wire own_flag = FD_NODE ? rx_frame.data[63 - sfdwe_pkg::FLAG_FD_POS]
                            : rx_frame.data[63 - sfdwe_pkg::FLAG_CL_POS];
    wire wake_on = wake_seen && own_flag;
    wire wake_off = wake_seen && !own_flag;
    wire mode_done = (mode_cnt == 8'(MODE_CLKS));
    wire in_operate = (state == sfdwe_pkg::SFDWE_OPERATE);

    // ****************
    // mode sequencer
    // ****************
    always_comb
    begin
        next_state = state;
        unique case (state)
            sfdwe_pkg::SFDWE_LISTEN:
                if (wake_on)
                    next_state = sfdwe_pkg::SFDWE_RESET;
            sfdwe_pkg::SFDWE_RESET:
                next_state = sfdwe_pkg::SFDWE_CHANGE;
            sfdwe_pkg::SFDWE_CHANGE:
                if (mode_done)
                    next_state = sfdwe_pkg::SFDWE_INTEGRATE;
            sfdwe_pkg::SFDWE_INTEGRATE:
                if (integ_done)
                    next_state = sfdwe_pkg::SFDWE_OPERATE;
            sfdwe_pkg::SFDWE_OPERATE:
                if (wake_off)
                    next_state = sfdwe_pkg::SFDWE_CANCEL;
            sfdwe_pkg::SFDWE_CANCEL:
                if (pending_empty)
                    next_state = sfdwe_pkg::SFDWE_HALT;
            sfdwe_pkg::SFDWE_HALT:
                next_state = sfdwe_pkg::SFDWE_LISTEN;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            state <= sfdwe_pkg::SFDWE_LISTEN;
        else
            state <= next_state;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            mode_cnt <= 8'h00;
        else if (state != sfdwe_pkg::SFDWE_CHANGE)
            mode_cnt <= 8'h00;
        else if (!mode_done)
            mode_cnt <= mode_cnt + 8'h01;
    end

    sfdwe_idle_counter #(
        .NEED(sfdwe_pkg::INTEGRATION_BITS)
    ) u_idle (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clear(state != sfdwe_pkg::SFDWE_INTEGRATE),
        .bit_en(bit_en),
        .rx_level(rx_level),
        .done(integ_done)
    );

    // ****************
    // core control outputs
    // ****************
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_mode <= sfdwe_pkg::MODE_RX_ONLY;
            clear_errors <= 1'b0;
            cancel_pending <= 1'b0;
            tx_drive_allow <= 1'b0;
            listen_enable <= 1'b1;
        end
        else
        begin
            unique case (next_state)
                sfdwe_pkg::SFDWE_RESET: ctrl_mode <= sfdwe_pkg::MODE_RESET;
                sfdwe_pkg::SFDWE_CHANGE: ctrl_mode <= sfdwe_pkg::MODE_RESET;
                sfdwe_pkg::SFDWE_INTEGRATE: ctrl_mode <= sfdwe_pkg::MODE_OPERATE;
                sfdwe_pkg::SFDWE_OPERATE: ctrl_mode <= sfdwe_pkg::MODE_OPERATE;
                sfdwe_pkg::SFDWE_CANCEL: ctrl_mode <= sfdwe_pkg::MODE_OPERATE;
                sfdwe_pkg::SFDWE_HALT: ctrl_mode <= sfdwe_pkg::MODE_HALT;
                default: ctrl_mode <= sfdwe_pkg::MODE_RX_ONLY;
            endcase
            clear_errors <= (next_state == sfdwe_pkg::SFDWE_RESET);
            cancel_pending <= (next_state == sfdwe_pkg::SFDWE_CANCEL);
            tx_drive_allow <= (next_state == sfdwe_pkg::SFDWE_OPERATE)
                || (next_state == sfdwe_pkg::SFDWE_CANCEL);
            listen_enable <= (next_state != sfdwe_pkg::SFDWE_RESET)
                && (next_state != sfdwe_pkg::SFDWE_CHANGE);
        end
    end

    // ****************
    // echo of received frames
    // ****************
    wire echo_take = in_operate && echo_enable && rx_valid && !wake_seen && !echo_pending;
    wire echo_drop = (state != sfdwe_pkg::SFDWE_OPERATE) && (state != sfdwe_pkg::SFDWE_CANCEL);

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            echo_pending <= 1'b0;
            echo_frame <= '0;
        end
        else if (echo_drop || (state == sfdwe_pkg::SFDWE_CANCEL))
            echo_pending <= 1'b0;
        else if (echo_take)
        begin
            echo_pending <= 1'b1;
            echo_frame <= '{id: rx_frame.id ^ sfdwe_pkg::ECHO_ID_XOR, dlc: rx_frame.dlc, data: rx_frame.data};
        end
        // besides a cancel or leaving operate, only a real handshake retires the echo, an early ready must not lose it
        else if (echo_pending && tx_valid && tx_ready)
            echo_pending <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_valid <= 1'b0;
            tx_frame <= '0;
        end
        else
        begin
            tx_valid <= echo_pending && in_operate && !(tx_valid && tx_ready);
            tx_frame <= echo_frame;
        end
    end

    // ****************
    // software registers
    // ****************
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            echo_enable <= 1'b1;
        else if (reg_write && reg_addr == REG_CTRL)
            echo_enable <= reg_wdata[0];
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            wake_count <= 16'h0000;
        else if (reg_write && reg_addr == REG_COUNT)
            wake_count <= 16'h0000;
        else if (wake_seen)
            wake_count <= wake_count + 16'h0001;
    end

    wire [31:0] status_word = {25'h000_0000, echo_pending, tx_drive_allow, ctrl_mode, 3'(state)};
    wire [31:0] read_mux = (reg_addr == REG_CTRL) ? {31'h0000_0000, echo_enable} :
                           (reg_addr == REG_STATUS) ? status_word :
                           (reg_addr == REG_COUNT) ? {16'h0000, wake_count} : 32'h0000_0000;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= 32'h0000_0000;
        else if (reg_read)
            reg_rdata <= read_mux;
        else
            reg_rdata <= 32'h0000_0000;
    end
endmodule : sfdwe_top

// File: sim/sfdwe_gateway.sv
/* gateway partner model: sends classical wake and data frames and drives the bus level.
   assumes one bench process calls its tasks. */
`timescale 1ns/1ps
module sfdwe_gateway (
    // clock
    input wire logic ref_clk,
    // frames and bus level
    output sfdwe_pkg::sfdwe_frame_t rx_frame,
    output logic rx_valid,
    output logic can_rx
);
    // ****
    // frame sender
    // ****
    initial
    begin
        rx_frame = '0;
        rx_valid = 1'b0;
        can_rx = 1'b1;
    end
    // fl is {fd_group_enable, classical enable}
    task automatic frame(input logic [10:0] id, input logic [1:0] fl);
        @(posedge ref_clk);
        can_rx <= 1'b0;
        repeat (6) @(posedge ref_clk);
        can_rx <= 1'b1;
        rx_valid <= 1'b1;
        rx_frame <= {id, 4'h8, fl, 2'h0, 60'h123_4567_89AB_CDEF};
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        rx_frame <= ~rx_frame;
        @(posedge ref_clk);
    endtask : frame
    task automatic noise(input int n);
        @(posedge ref_clk);
        can_rx <= 1'b0;
        repeat (n) @(posedge ref_clk);
        can_rx <= 1'b1;
    endtask : noise
endmodule : sfdwe_gateway

// File: sim/sfdwe_assertions.sv
/* port assertions for the mode controller.
   assumes it is bound to sfdwe_top with the same parameters. */
`timescale 1ns/1ps
module sfdwe_assertions #(
    parameter int unsigned MODE_CLKS = 50,
    parameter int unsigned BIT_CYCLES = 50,
    parameter bit FD_NODE = 1'b0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // bus and frames
    input wire logic can_rx,
    input wire logic rx_valid,
    input wire sfdwe_pkg::sfdwe_frame_t rx_frame,
    input wire logic tx_valid,
    input wire sfdwe_pkg::sfdwe_frame_t tx_frame,
    input wire logic tx_ready,
    // core control
    input wire logic [1:0] ctrl_mode,
    input wire logic clear_errors,
    input wire logic cancel_pending,
    input wire logic tx_drive_allow,
    input wire logic listen_enable,
    input wire logic pending_empty
);
    // ****
    // checks
    // ****
    logic [15:0] idle_run;
    logic [15:0] deaf_run;
    wire wake = rx_valid && rx_frame.id == 11'h000 && rx_frame.dlc != 4'h0 && rx_frame.data[FD_NODE ? 63 : 62];
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            idle_run <= 16'h0000;
            deaf_run <= 16'h0000;
        end
        else
        begin
            idle_run <= !can_rx ? 16'h0000 : idle_run + 16'(idle_run != 16'hFFFF);
            deaf_run <= listen_enable ? 16'h0000 : deaf_run + 16'h0001;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    AST_START: assert property ($rose(reset_n) |-> ctrl_mode == 2'h0 && listen_enable)
        else $error("not listening after reset");
    AST_WAKE: assert property (wake && ctrl_mode == 2'h0 |=> ctrl_mode == 2'h1 && clear_errors)
        else $error("wake frame did not enter reset mode");
    AST_PULSE: assert property (clear_errors |=> !clear_errors)
        else $error("clear pulse too long");
    AST_DEAF: assert property ($fell(listen_enable) |-> (!listen_enable && !tx_drive_allow) [*8])
        else $error("bus watched during mode change");
    AST_DELAY: assert property ($rose(listen_enable) |-> deaf_run >= MODE_CLKS)
        else $error("mode change delay too short");
    AST_INTEG: assert property ($rose(tx_drive_allow) |-> idle_run >= 16'(12 * BIT_CYCLES))
        else $error("drive allowed before integration");
    AST_QUIET: assert property (ctrl_mode == 2'h0 |-> !tx_drive_allow && !cancel_pending)
        else $error("drive allowed in receive-only");
    AST_CANCEL: assert property (cancel_pending && !pending_empty |=> cancel_pending)
        else $error("cancel ended early");
    AST_HALT: assert property (cancel_pending && pending_empty |=> ctrl_mode == 2'h2 ##1 ctrl_mode == 2'h0)
        else $error("halt step missing");
    AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
        else $error("echo offer not held");
endmodule : sfdwe_assertions
bind sfdwe_top sfdwe_assertions #(.MODE_CLKS(MODE_CLKS), .BIT_CYCLES(BIT_CYCLES), .FD_NODE(FD_NODE)) u_chk (
    .ref_clk, .reset_n, .can_rx, .rx_valid, .rx_frame, .tx_valid, .tx_frame, .tx_ready,
    .ctrl_mode, .clear_errors, .cancel_pending, .tx_drive_allow, .listen_enable, .pending_empty);

// File: sim/sfdwe_top_tb.sv
/* self-checking bench for sfdwe_top fed by the gateway model.
   assumes short mode and bit counts. */
`timescale 1ns/1ps
module sfdwe_top_tb;
    // ****
    // bench
    // ****
    localparam int unsigned BITC = 4;
    logic ref_clk, reset_n, can_rx, rx_valid, tx_valid, tx_ready, clear_errors, cancel_pending;
    logic tx_drive_allow, listen_enable, pending_empty, reg_write, reg_read;
    logic [1:0] ctrl_mode;
    logic [1:0] fd_ctrl_mode;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    sfdwe_pkg::sfdwe_frame_t rx_frame, tx_frame;
    int fails, num_checks, n;
    sfdwe_gateway gw (.ref_clk, .rx_frame, .rx_valid, .can_rx);
    sfdwe_top #(.MODE_CLKS(10), .BIT_CYCLES(BITC), .FD_NODE(1'b0)) DUT (
        .ref_clk, .reset_n, .can_rx, .rx_valid, .rx_frame, .tx_valid, .tx_frame, .tx_ready,
        .ctrl_mode, .clear_errors, .cancel_pending, .tx_drive_allow, .listen_enable,
        .pending_empty, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
    // fd-capable node on the same bus, acting on the fd flag
    sfdwe_top #(.MODE_CLKS(10), .BIT_CYCLES(BITC), .FD_NODE(1'b1)) DUT_FD (
        .ref_clk, .reset_n, .can_rx, .rx_valid, .rx_frame, .tx_valid(), .tx_frame(), .tx_ready,
        .ctrl_mode(fd_ctrl_mode), .clear_errors(), .cancel_pending(), .tx_drive_allow(), .listen_enable(),
        .pending_empty, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata());
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic conclude;
        if (fails == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // {mode, listen, drive, cancel}
    task automatic chk_port(input logic [4:0] exp);
        #1 num_checks++;
        if ({ctrl_mode, listen_enable, tx_drive_allow, cancel_pending} !== exp)
        begin
            fails++;
            $display("mismatch at %0t: port state %h", $time, exp);
        end
    endtask : chk_port
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    task automatic wt(input int sel, input logic v);
        for (n = 0; n < 2000; n++)
        begin
            @(posedge ref_clk);
            #1;
            if ((sel == 0 ? tx_drive_allow : sel == 1 ? tx_valid : ctrl_mode == 2'h0) === v)
                break;
        end
        if (n == 2000)
        begin
            fails++;
            $display("mismatch at %0t: wait ran out", $time);
            conclude();
        end
    endtask : wt
    initial
    begin
        reset_n = 1'b0;
        {tx_ready, pending_empty, reg_write, reg_read} = 4'h0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0000_0000;
        {fails, num_checks} = 0;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        chk_port(5'h04);
        rd(4'h4, 32'h0000_0000);
        rd(4'h0, 32'h0000_0001);
        wr(4'hC, 32'h0000_0005);
        rd(4'hC, 32'h0000_0000);
        // fd off, fd on and a non-wake id stay listening
        for (int i = 0; i < 3; i++)
        begin
            gw.frame(i == 2 ? 11'h005 : 11'h000, i == 1 ? 2'b10 : {1'b0, i == 2});
            chk_port(5'h04);
            if (i == 1)
                chk({30'h0000_0000, fd_ctrl_mode}, 32'h0000_0001);
        end
        gw.frame(11'h000, 2'b01);
        gw.frame(11'h000, 2'b01);
        repeat (11 * BITC) @(posedge ref_clk);
        gw.noise(8);
        wt(0, 1'b1);
        chk({31'h0, n >= 12 * BITC}, 32'h0000_0001);
        chk_port(5'h1E);
        rd(4'h4, 32'h0000_003C);
        rd(4'h8, 32'h0000_0004);
        wr(4'h8, 32'h0000_0000);
        rd(4'h8, 32'h0000_0000);
        gw.frame(11'h123, 2'b00);
        wt(1, 1'b1);
        chk({21'h0, tx_frame.id}, 32'h0000_0122);
        chk(tx_frame.data[31:0], 32'h89AB_CDEF);
        @(posedge ref_clk);
        tx_ready <= 1'b1;
        @(posedge ref_clk);
        tx_ready <= 1'b0;
        #1 chk({31'h0, tx_valid}, 32'h0000_0000);
        wr(4'h0, 32'h0000_0000);
        gw.frame(11'h045, 2'b00);
        repeat (4) @(posedge ref_clk);
        #1 chk({31'h0, tx_valid}, 32'h0000_0000);
        wr(4'h0, 32'h0000_0001);
        gw.frame(11'h000, 2'b10);
        repeat (3) @(posedge ref_clk);
        #1 chk({31'h0, cancel_pending}, 32'h0000_0001);
        @(posedge ref_clk);
        pending_empty <= 1'b1;
        wt(2, 1'b1);
        chk_port(5'h04);
        rd(4'h4, 32'h0000_0000);
        chk({30'h0000_0000, fd_ctrl_mode}, 32'h0000_0003);
        conclude();
    end
endmodule : sfdwe_top_tb
